/* cfgsh_pkg.sv */
// Purpose: Constants and types for the configuration shadow and nonvolatile store
// Assumes: 16-bit addressed locations, 32-bit shadow registers
// Notes:   Offsets are the low 12 address bits; section and page must be zero
package cfgsh_pkg;
  // ==========================================================
  // Store geometry
  localparam int WORD_BITS    = 32;
  localparam int NV_ROWS      = 16;
  localparam int ROW_BITS     = 64;
  localparam int NV_WORDS     = NV_ROWS * ROW_BITS / WORD_BITS;
  localparam int SHADOW_COUNT = 20;
  localparam int ADDR_BITS    = 12;
  localparam logic [4:0] LAST_ROW  = 5'h0f;
  localparam logic [4:0] LAST_SHAD = 5'h13;
  // ==========================================================
  // Register offsets
  localparam logic [11:0] OFS_SPEED_DETECT_CFG      = 12'h080;
  localparam logic [11:0] OFS_STARTUP_CFG_A         = 12'h082;
  localparam logic [11:0] OFS_STARTUP_CFG_B         = 12'h084;
  localparam logic [11:0] OFS_RUN_LOOP_CFG_A        = 12'h086;
  localparam logic [11:0] OFS_RUN_LOOP_CFG_B        = 12'h088;
  localparam logic [11:0] OFS_RUN_LOOP_CFG_C        = 12'h08a;
  localparam logic [11:0] OFS_RUN_LOOP_CFG_D        = 12'h08c;
  localparam logic [11:0] OFS_SPEED_REGULATION_CFG  = 12'h08e;
  localparam logic [11:0] OFS_POWER_REGULATION_CFG  = 12'h090;
  localparam logic [11:0] OFS_FAULT_CFG_A           = 12'h092;
  localparam logic [11:0] OFS_FAULT_CFG_B           = 12'h094;
  localparam logic [11:0] OFS_WIDE_MOD_TWO_PHASE    = 12'h096;
  localparam logic [11:0] OFS_WIDE_MOD_THREE_PHASE  = 12'h098;
  localparam logic [11:0] OFS_ALGORITHM_CFG_A       = 12'h09a;
  localparam logic [11:0] OFS_ALGORITHM_CFG_B       = 12'h09c;
  localparam logic [11:0] OFS_PIN_FUNCTION_CFG_A    = 12'h0a4;
  localparam logic [11:0] OFS_PIN_FUNCTION_CFG_B    = 12'h0a6;
  localparam logic [11:0] OFS_DEVICE_SETTINGS       = 12'h0a8;
  localparam logic [11:0] OFS_GATE_DRIVE_CFG_A      = 12'h0ac;
  localparam logic [11:0] OFS_GATE_DRIVE_CFG_B      = 12'h0ae;
  localparam logic [11:0] OFS_NONVOLATILE_COMMAND   = 12'h0e6;
  // Shadow slot n sits at entry n; slot n is nonvolatile word n
  localparam logic [SHADOW_COUNT-1:0][11:0] SHADOW_MAP = {
    OFS_GATE_DRIVE_CFG_B, OFS_GATE_DRIVE_CFG_A, OFS_DEVICE_SETTINGS,
    OFS_PIN_FUNCTION_CFG_B, OFS_PIN_FUNCTION_CFG_A, OFS_ALGORITHM_CFG_B,
    OFS_ALGORITHM_CFG_A, OFS_WIDE_MOD_THREE_PHASE, OFS_WIDE_MOD_TWO_PHASE,
    OFS_FAULT_CFG_B, OFS_FAULT_CFG_A, OFS_POWER_REGULATION_CFG,
    OFS_SPEED_REGULATION_CFG, OFS_RUN_LOOP_CFG_D, OFS_RUN_LOOP_CFG_C,
    OFS_RUN_LOOP_CFG_B, OFS_RUN_LOOP_CFG_A, OFS_STARTUP_CFG_B,
    OFS_STARTUP_CFG_A, OFS_SPEED_DETECT_CFG};
  localparam logic [11:0] ADDR_STEP   = 12'h002;
  localparam logic [31:0] CMD_COMMIT  = 32'h8a500000;
  localparam logic [31:0] CMD_LOAD    = 32'h40000000;
  // ==========================================================
  // Control word layout and byte counts
  localparam int CW_OP_READ    = 23;
  localparam int CW_CRC_EN     = 22;
  localparam int CW_LEN_LSB    = 20;
  localparam int CW_REGION_LSB = 12;
  localparam logic [1:0] LEN_16 = 2'h0;
  localparam logic [1:0] LEN_32 = 2'h1;
  localparam logic [1:0] LEN_64 = 2'h2;
  localparam logic [3:0] BYTES_16     = 4'h2;
  localparam logic [3:0] BYTES_32     = 4'h4;
  localparam logic [3:0] BYTES_64     = 4'h8;
  localparam logic [3:0] CTRL_LAST    = 4'h3;
  localparam logic [3:0] FIRST_DATA   = 4'h4;
  localparam logic [3:0] BYTE_CNT_MAX = 4'hf;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [31:0] COMMIT_CYCLES = 32'd48;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {LS_IDLE, LS_RX, LS_ACK_WAIT, LS_ACK_HOLD, LS_TX, LS_TX_ACK}
    cfgsh_link_e;
  typedef enum logic [2:0] {NV_IDLE, NV_ERASE, NV_PROG_LO, NV_PROG_HI, NV_LOAD} cfgsh_nv_e;
  typedef struct packed {
    logic scl_s1, scl_s2, scl_s3, scl_f, sda_s1, sda_s2, sda_s3, sda_f;
    cfgsh_link_e lstate;
    logic [2:0]  bit_cnt;
    logic [3:0]  byte_cnt;
    logic [7:0]  shreg;
    logic        is_read, do_ack, sda_drive;
    logic [23:0] ctrl;
    logic [63:0] wdata;
    logic        req_tgl, req_rd;
    logic [23:0] req_ctrl;
    logic [63:0] req_data;
    logic        ack_s1, ack_s2, ack_s3, ack_seen, rd_ok;
    logic [63:0] rd_buf;
    logic [2:0]  tx_idx;
  } cfgsh_link_s;
  typedef struct packed {
    logic req_s1, req_s2, req_s3, req_seen, mot_s1, mot_s2, mot_s3, mot_f;
    logic        ack_tgl;
    logic [63:0] rdata;
    cfgsh_nv_e   nv_state;
    logic [4:0]  cnt;
    logic [SHADOW_COUNT-1:0][WORD_BITS-1:0] shadow;
    logic [NV_WORDS-1:0][WORD_BITS-1:0]     nv;
  } cfgsh_sys_s;
endpackage

/* cfgsh_nv_access.sv */
// Purpose: Two-wire target with shadow registers and a nonvolatile store behind them
// Assumes: sys_clk 50 MHz; link_clk oversamples the bus pins; open-drain data pin
// Notes:   Bus engine on link_clk, registers and store on sys_clk, toggle handshake between
// How it works
// - Store holds 1024 bits as 16 rows of 64 bits.
// - Erase clears a whole 64-bit row in one step.
// - Programming and reading the store go 32 bits at a time.
// - No bus command exists that erases a row on its own.
// - Shadow registers live from 0x080 to 0x0ae and mirror the store.
// - Store commands are ignored while the motor is spinning.
// - Writing 0x8a500000 to 0x0e6 copies all shadow registers into the store.
// - Writing 0x40000000 to 0x0e6 loads the store into the shadow registers.
// - Each address is 16 bits wide; 32-bit registers sit two apart.
// - First shadow register at 0x080 holds speed detection settings.
// - Target on the two-wire bus; every shadow register readable and writable, command register reads zero.
// - Length field: 00 is 16, 01 is 32, 10 is 64 bits, 11 reserved.
// - A 64-bit access is two 32-bit accesses at address and address plus 2.
// - Data bytes travel least significant byte first both ways.
// - A write whose data byte count mismatches the length, plus one check byte when CRC is on, is dropped.
`timescale 1ns/1ps
`default_nettype none
module cfgsh_nv_access #(
  parameter logic [6:0] TARGET_ID = 7'h00  // Bus target address
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    link_clk,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_n,
  input  wire logic                    motor_spinning,
  output logic                         nv_busy,
  output logic [cfgsh_pkg::SHADOW_COUNT*cfgsh_pkg::WORD_BITS-1:0] cfg_words
);

  cfgsh_pkg::cfgsh_link_s lq, ln;
  cfgsh_pkg::cfgsh_sys_s  sq, sn;

  // ==========================================================
  // Decode helpers
  // Shadow slot lookup: bit 5 is the hit flag
  function automatic logic [5:0] shadow_index(input logic [11:0] a);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < cfgsh_pkg::SHADOW_COUNT; i++) begin
      if (cfgsh_pkg::SHADOW_MAP[i] == a) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // Register read, reserved and command locations give zero
  function automatic logic [31:0] read_unit(input logic [11:0] a,
    input logic [cfgsh_pkg::SHADOW_COUNT-1:0][31:0] sh);
    logic [5:0] h;
    h = shadow_index(a);
    return h[5] ? sh[h[4:0]] : 32'h0;
  endfunction

  // Data bytes expected for a control word, zero when length is reserved
  function automatic logic [3:0] exp_bytes(input logic [23:0] cw);
    logic [3:0] n;
    unique case (cw[cfgsh_pkg::CW_LEN_LSB +: 2])
      cfgsh_pkg::LEN_16: n = cfgsh_pkg::BYTES_16;
      cfgsh_pkg::LEN_32: n = cfgsh_pkg::BYTES_32;
      cfgsh_pkg::LEN_64: n = cfgsh_pkg::BYTES_64;
      default:           n = 4'h0;
    endcase
    if (n != 4'h0 && cw[cfgsh_pkg::CW_CRC_EN]) begin
      n = n + 4'h1;
    end
    return n;
  endfunction

  // ==========================================================
  // Link side: pin filtering and byte engine
  logic scl_now, sda_now, scl_rise, scl_fall, bus_start, bus_stop;
  logic ack_ev, write_end, len_ok, byte_done;
  logic [7:0] rx_byte;
  logic [3:0] data_cnt;
  always_comb begin
    scl_now   = (lq.scl_s2 == lq.scl_s3) ? lq.scl_s3 : lq.scl_f;
    sda_now   = (lq.sda_s2 == lq.sda_s3) ? lq.sda_s3 : lq.sda_f;
    scl_rise  = scl_now & ~lq.scl_f;
    scl_fall  = ~scl_now & lq.scl_f;
    bus_start = scl_now & lq.scl_f & lq.sda_f & ~sda_now;
    bus_stop  = scl_now & lq.scl_f & ~lq.sda_f & sda_now;
    ack_ev    = (lq.ack_s2 == lq.ack_s3) && (lq.ack_s3 != lq.ack_seen);
    rx_byte   = {lq.shreg[6:0], sda_now};
    byte_done = (lq.lstate == cfgsh_pkg::LS_RX) && scl_rise && lq.bit_cnt == cfgsh_pkg::LAST_BIT;
    data_cnt  = lq.byte_cnt - cfgsh_pkg::FIRST_DATA;
    write_end = (bus_start | bus_stop) && lq.lstate != cfgsh_pkg::LS_IDLE && !lq.is_read &&
                lq.byte_cnt >= cfgsh_pkg::FIRST_DATA && !lq.ctrl[cfgsh_pkg::CW_OP_READ];
    len_ok    = exp_bytes(lq.ctrl) != 4'h0 && data_cnt == exp_bytes(lq.ctrl);
  end

  // Next link state
  always_comb begin
    ln = lq;
    ln.scl_s1 = scl_in;
    ln.scl_s2 = lq.scl_s1;
    ln.scl_s3 = lq.scl_s2;
    ln.sda_s1 = sda_in;
    ln.sda_s2 = lq.sda_s1;
    ln.sda_s3 = lq.sda_s2;
    ln.scl_f  = scl_now;
    ln.sda_f  = sda_now;
    ln.ack_s1 = sq.ack_tgl;
    ln.ack_s2 = lq.ack_s1;
    ln.ack_s3 = lq.ack_s2;
    // Read data arrives from the register side
    if (ack_ev) begin
      ln.ack_seen = lq.ack_s3;
      ln.rd_buf   = sq.rdata;
      ln.rd_ok    = 1'b1;
    end
    // Finished write goes across only when its length matches
    if (write_end && len_ok) begin
      ln.req_ctrl = lq.ctrl;
      ln.req_data = lq.wdata;
      ln.req_rd   = 1'b0;
      ln.req_tgl  = ~lq.req_tgl;
    end
    unique case (lq.lstate)
      cfgsh_pkg::LS_IDLE: begin
      end
      cfgsh_pkg::LS_RX: begin
        if (scl_rise) begin
          ln.shreg   = rx_byte;
          ln.bit_cnt = lq.bit_cnt + 3'h1;
        end
        if (byte_done) begin
          ln.lstate = cfgsh_pkg::LS_ACK_WAIT;
          ln.do_ack = 1'b1;
          if (lq.byte_cnt != cfgsh_pkg::BYTE_CNT_MAX) begin
            ln.byte_cnt = lq.byte_cnt + 4'h1;
          end
          if (lq.byte_cnt == 4'h0) begin
            ln.is_read = rx_byte[0];
            ln.do_ack  = rx_byte[7:1] == TARGET_ID && (!rx_byte[0] || lq.rd_ok);
          end else if (lq.byte_cnt <= cfgsh_pkg::CTRL_LAST) begin
            ln.ctrl = {lq.ctrl[15:0], rx_byte};
            if (lq.byte_cnt == cfgsh_pkg::CTRL_LAST && lq.ctrl[15]) begin
              ln.req_ctrl = {lq.ctrl[15:0], rx_byte};
              ln.req_rd   = 1'b1;
              ln.req_tgl  = ~lq.req_tgl;
              ln.rd_ok    = 1'b0;
            end
          end else if (data_cnt < cfgsh_pkg::BYTES_64) begin
            ln.wdata[{data_cnt[2:0], 3'h0} +: 8] = rx_byte;
          end
        end
      end
      cfgsh_pkg::LS_ACK_WAIT: begin
        if (scl_fall) begin
          ln.sda_drive = lq.do_ack;
          ln.lstate    = lq.do_ack ? cfgsh_pkg::LS_ACK_HOLD : cfgsh_pkg::LS_IDLE;
        end
      end
      cfgsh_pkg::LS_ACK_HOLD: begin
        if (scl_fall) begin
          ln.bit_cnt = 3'h0;
          if (lq.is_read) begin
            ln.shreg     = lq.rd_buf[{lq.tx_idx, 3'h0} +: 8];
            ln.sda_drive = ~lq.rd_buf[{lq.tx_idx, 3'h0} + 6'h07];
            ln.tx_idx    = lq.tx_idx + 3'h1;
            ln.lstate    = cfgsh_pkg::LS_TX;
          end else begin
            ln.sda_drive = 1'b0;
            ln.lstate    = cfgsh_pkg::LS_RX;
          end
        end
      end
      cfgsh_pkg::LS_TX: begin
        if (scl_fall) begin
          if (lq.bit_cnt == cfgsh_pkg::LAST_BIT) begin
            ln.sda_drive = 1'b0;
            ln.lstate    = cfgsh_pkg::LS_TX_ACK;
          end else begin
            ln.bit_cnt   = lq.bit_cnt + 3'h1;
            ln.sda_drive = ~lq.shreg[6];
            ln.shreg     = {lq.shreg[6:0], 1'b0};
          end
        end
      end
      cfgsh_pkg::LS_TX_ACK: begin
        if (scl_rise) begin
          ln.lstate = sda_now ? cfgsh_pkg::LS_IDLE : cfgsh_pkg::LS_ACK_HOLD;
        end
      end
    endcase
    // Start and stop override any byte in progress
    if (bus_start | bus_stop) begin
      ln.lstate    = bus_start ? cfgsh_pkg::LS_RX : cfgsh_pkg::LS_IDLE;
      ln.bit_cnt   = 3'h0;
      ln.byte_cnt  = 4'h0;
      ln.tx_idx    = 3'h0;
      ln.is_read   = 1'b0;
      ln.sda_drive = 1'b0;
    end
  end

  // Link state register
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lq <= '0;
    end else begin
      lq <= ln;
    end
  end

  // ==========================================================
  // Register side: requests, shadow file, store engine
  logic        req_ev, region_ok, cmd_hit;
  logic [11:0] a0, a1, ah;
  logic [23:0] rcw;
  logic [31:0] cmd;
  logic [4:0]  w_lo, w_hi;
  always_comb begin
    req_ev    = (sq.req_s2 == sq.req_s3) && (sq.req_s3 != sq.req_seen);
    rcw       = lq.req_ctrl;
    a0        = rcw[cfgsh_pkg::ADDR_BITS-1:0];
    a1        = a0 + cfgsh_pkg::ADDR_STEP;
    ah        = {a0[11:1], 1'b0};
    region_ok = rcw[cfgsh_pkg::CW_REGION_LSB +: 8] == 8'h00;
    w_lo      = {sq.cnt[3:0], 1'b0};
    w_hi      = {sq.cnt[3:0], 1'b1};
    cmd_hit   = 1'b0;
    cmd       = 32'h0;
    if (req_ev && region_ok && !lq.req_rd) begin
      if (rcw[cfgsh_pkg::CW_LEN_LSB +: 2] == cfgsh_pkg::LEN_16) begin
        cmd_hit = ah == cfgsh_pkg::OFS_NONVOLATILE_COMMAND && !a0[0];
        cmd     = {16'h0, lq.req_data[15:0]};
      end else if (rcw[cfgsh_pkg::CW_LEN_LSB +: 2] != 2'h3) begin
        cmd_hit = a0 == cfgsh_pkg::OFS_NONVOLATILE_COMMAND;
        cmd     = lq.req_data[31:0];
      end
    end
  end

  // Next register-side state
  always_comb begin
    logic [5:0] h;
    logic       unit_en;
    logic [11:0] ua;
    h       = 6'h00;
    unit_en = 1'b0;
    ua      = 12'h000;
    sn = sq;
    sn.req_s1 = lq.req_tgl;
    sn.req_s2 = sq.req_s1;
    sn.req_s3 = sq.req_s2;
    sn.mot_s1 = motor_spinning;
    sn.mot_s2 = sq.mot_s1;
    sn.mot_s3 = sq.mot_s2;
    if (sq.mot_s2 == sq.mot_s3) begin
      sn.mot_f = sq.mot_s3;
    end
    if (req_ev) begin
      sn.req_seen = sq.req_s3;
    end
    // Shadow writes, dropped while the store engine owns the shadow file
    if (req_ev && region_ok && !lq.req_rd && sq.nv_state == cfgsh_pkg::NV_IDLE) begin
      if (rcw[cfgsh_pkg::CW_LEN_LSB +: 2] == cfgsh_pkg::LEN_16) begin
        h = shadow_index(ah);
        if (h[5]) begin
          sn.shadow[h[4:0]][{a0[0], 4'h0} +: 16] = lq.req_data[15:0];
        end
      end
      for (int u = 0; u < 2; u++) begin
        unit_en = rcw[cfgsh_pkg::CW_LEN_LSB +: 2] == cfgsh_pkg::LEN_64 ||
                  (u == 0 && rcw[cfgsh_pkg::CW_LEN_LSB +: 2] == cfgsh_pkg::LEN_32);
        ua = (u == 0) ? a0 : a1;
        h  = shadow_index(ua);
        if (unit_en && h[5]) begin
          sn.shadow[h[4:0]] = lq.req_data[u*32 +: 32];
        end
      end
    end
    // Read answer, low unit in the low bytes
    if (req_ev && lq.req_rd) begin
      sn.ack_tgl = ~sq.ack_tgl;
      sn.rdata   = 64'h0;
      if (region_ok) begin
        unique case (rcw[cfgsh_pkg::CW_LEN_LSB +: 2])
          cfgsh_pkg::LEN_16: sn.rdata = {48'h0, 16'(read_unit(ah, sq.shadow) >> {a0[0], 4'h0})};
          cfgsh_pkg::LEN_32: sn.rdata = {32'h0, read_unit(a0, sq.shadow)};
          cfgsh_pkg::LEN_64: sn.rdata = {read_unit(a1, sq.shadow), read_unit(a0, sq.shadow)};
          default:           sn.rdata = 64'h0;
        endcase
      end
    end
    // Command decode; only the two codes start anything, never while spinning
    if (cmd_hit && sq.nv_state == cfgsh_pkg::NV_IDLE && !sq.mot_f) begin
      sn.cnt = 5'h00;
      if (cmd == cfgsh_pkg::CMD_COMMIT) begin
        sn.nv_state = cfgsh_pkg::NV_ERASE;
      end else if (cmd == cfgsh_pkg::CMD_LOAD) begin
        sn.nv_state = cfgsh_pkg::NV_LOAD;
      end
    end
    // Store engine: per row erase, then two 32-bit programs
    unique case (sq.nv_state)
      cfgsh_pkg::NV_IDLE: begin
      end
      cfgsh_pkg::NV_ERASE: begin
        sn.nv[w_lo] = 32'h0;
        sn.nv[w_hi] = 32'h0;
        sn.nv_state = cfgsh_pkg::NV_PROG_LO;
      end
      cfgsh_pkg::NV_PROG_LO: begin
        sn.nv[w_lo] = (w_lo <= cfgsh_pkg::LAST_SHAD) ? sq.shadow[w_lo] : 32'h0;
        sn.nv_state = cfgsh_pkg::NV_PROG_HI;
      end
      cfgsh_pkg::NV_PROG_HI: begin
        sn.nv[w_hi] = (w_hi <= cfgsh_pkg::LAST_SHAD) ? sq.shadow[w_hi] : 32'h0;
        sn.cnt      = sq.cnt + 5'h01;
        sn.nv_state = (sq.cnt == cfgsh_pkg::LAST_ROW) ? cfgsh_pkg::NV_IDLE : cfgsh_pkg::NV_ERASE;
      end
      cfgsh_pkg::NV_LOAD: begin
        sn.shadow[sq.cnt] = sq.nv[sq.cnt];
        sn.cnt            = sq.cnt + 5'h01;
        if (sq.cnt == cfgsh_pkg::LAST_SHAD) begin
          sn.nv_state = cfgsh_pkg::NV_IDLE;
        end
      end
      default: sn.nv_state = cfgsh_pkg::NV_IDLE;
    endcase
  end

  // Register-side state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sq <= '0;
    end else begin
      sq <= sn;
    end
  end

  // Outputs
  assign sda_out   = 1'b0;  // Open drain, only ever pulls low
  assign sda_oe_n  = ~lq.sda_drive;
  assign nv_busy   = sq.nv_state != cfgsh_pkg::NV_IDLE;
  assign cfg_words = sq.shadow;
  // ==========================================================
  // Checks
  sequence s_row_cycle;
    sq.nv_state == cfgsh_pkg::NV_ERASE ##1 sq.nv_state == cfgsh_pkg::NV_PROG_LO
      ##1 sq.nv_state == cfgsh_pkg::NV_PROG_HI;
  endsequence
  a_row_sequence: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sq.nv_state == cfgsh_pkg::NV_ERASE |-> s_row_cycle)
    else $error("row erase not followed by two programs");
  a_erase_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sq.nv_state == cfgsh_pkg::NV_ERASE |=> sq.nv[$past(w_lo)] == 32'h0)
    else $error("erase left data in row");
  a_prog_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sq.nv_state == cfgsh_pkg::NV_PROG_LO && w_lo <= cfgsh_pkg::LAST_SHAD
      |=> sq.nv[$past(w_lo)] == sq.shadow[$past(w_lo)])
    else $error("programmed word differs from shadow");
  a_load_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sq.nv_state == cfgsh_pkg::NV_LOAD |=> sq.shadow[$past(sq.cnt)] == sq.nv[$past(sq.cnt)])
    else $error("load did not copy store word");
  a_commit_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_hit && cmd == cfgsh_pkg::CMD_COMMIT && !nv_busy && !sq.mot_f
      |=> sq.nv_state == cfgsh_pkg::NV_ERASE && sq.cnt == 5'h00)
    else $error("commit command did not start");
  a_load_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_hit && cmd == cfgsh_pkg::CMD_LOAD && !nv_busy && !sq.mot_f
      |=> sq.nv_state == cfgsh_pkg::NV_LOAD)
    else $error("load command did not start");
  a_spin_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_hit && sq.mot_f && !nv_busy |=> !nv_busy)
    else $error("store started while spinning");
  a_bad_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_hit && !nv_busy && cmd != cfgsh_pkg::CMD_COMMIT && cmd != cfgsh_pkg::CMD_LOAD
      |=> !nv_busy)
    else $error("unknown command started store");
  a_commit_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !nv_busy ##1 sq.nv_state == cfgsh_pkg::NV_ERASE |-> ##48 !nv_busy)
    else $error("commit did not cover sixteen rows");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req_ev && lq.req_rd |=> sq.ack_tgl != $past(sq.ack_tgl))
    else $error("read request got no answer");
  a_len_drop: assert property (@(posedge link_clk) disable iff (!rst_n)
    write_end && !len_ok && !byte_done |=> $stable(lq.req_tgl))
    else $error("mismatched write was forwarded");
  a_nack_release: assert property (@(posedge link_clk) disable iff (!rst_n)
    lq.lstate == cfgsh_pkg::LS_ACK_WAIT && !lq.do_ack |-> !lq.sda_drive)
    else $error("data pin driven on refused byte");
endmodule
`default_nettype wire

/* cfgsh_ctrl_model.sv */
// Purpose: Bus controller model facing the config target
// Assumes: Pull-up on data; QTR link cycles per quarter bit
// Notes:   Byte gaps scaled far below the real controller wait
`timescale 1ns/1ps
`default_nettype none
module cfgsh_ctrl_model #(
  parameter int QTR = 10
) (
  input  wire logic link_clk,
  input  wire logic sda_wire,
  output var  logic scl,
  output var  logic sda_drv
);
  // ==========
  // Bus phases
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic pin(input logic c, input logic d);
    scl = c;
    sda_drv = d;
    repeat (QTR) @(negedge link_clk);
  endtask
  task automatic start();
    pin(scl, 1'b1);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
  endtask
  task automatic stop();
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
  endtask
  // Byte MSB first plus ninth bit; ack is data low there
  task automatic xfer(input logic [7:0] d, input logic nb, output logic [7:0] r,
                      output logic ack);
    logic [8:0] w;
    logic [8:0] s;
    w = {d, nb};
    for (int i = 8; i >= 0; i--) begin
      pin(1'b0, w[i]);
      pin(1'b1, w[i]);
      s[i] = sda_wire;
      pin(1'b1, w[i]);
      pin(1'b0, w[i]);
    end
    repeat (QTR) @(negedge link_clk);  // Byte gap
    r = s[8:1];
    ack = ~s[0];
  endtask
  // Id byte then three control bytes; l[2] is the CRC enable
  task automatic head(input logic rd, input logic [2:0] l, input logic [11:0] a,
                      output logic ok);
    logic [31:0] b;
    logic [7:0]  r;
    logic        k;
    b = {8'h00, rd, l, 8'h00, a};
    ok = 1'b1;
    start();
    for (int i = 3; i >= 0; i--) begin
      xfer(b[8*i+:8], 1'b1, r, k);
      ok &= k;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [2:0] l, input logic [63:0] d,
                    input int n, output logic ok);
    logic [7:0] r;
    logic       k;
    head(1'b0, l, a, ok);
    for (int i = 0; i < n; i++) begin
      xfer(d[8*i+:8], 1'b1, r, k);
      ok &= k;
    end
    stop();
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] l, input int n,
                    output logic [63:0] d);
    logic [7:0] r;
    logic       k;
    head(1'b1, {1'b0, l}, a, k);
    start();
    xfer(8'h01, 1'b1, r, k);
    d = '0;
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i == n - 1, r, k);
      d[8*i+:8] = r;
    end
    stop();
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for config shadow and store
// Assumes: Default target id; inputs change on clock falls
// Notes:   Store timings follow the short engine counts
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        motor_spinning = 1'b0;
  logic        scl, sda_drv, sda_out, sda_oe_n, nv_busy, ok;
  logic [639:0] cfg_words;
  logic [63:0] rv;
  wire         sda_wire = sda_drv & (sda_oe_n | sda_out);
  int          error_cnt = 0;
  int          compares = 0;
  // ==========
  // Clocks and parts
  always #10 sys_clk = ~sys_clk;
  always #3 link_clk = ~link_clk;  // Edges meet sys_clk edges every 30 ns
  cfgsh_nv_access dut (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .motor_spinning(motor_spinning), .nv_busy(nv_busy), .cfg_words(cfg_words));
  cfgsh_ctrl_model bus (.link_clk(link_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
  // ==========
  // Helpers
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] slot(input int n);
    return cfg_words[32*n+:32];
  endfunction
  task automatic put(input logic [11:0] a, input logic [1:0] l, input logic [63:0] d, input int n);
    bus.wr(a, {1'b0, l}, d, n, ok);
    chk("ack", ok, 1);
    repeat (12) @(negedge sys_clk);
  endtask
  // Busy length in cycles, zero when refused
  task automatic nv_cmd(input logic [31:0] c, input logic mot, input int dur);
    int k;
    motor_spinning = mot;
    bus.wr(cfgsh_pkg::OFS_NONVOLATILE_COMMAND, {1'b0, cfgsh_pkg::LEN_32}, {32'h0, c}, 4, ok);
    k = 0;
    while (nv_busy !== 1'b1 && k < 30) begin
      @(negedge sys_clk);
      k++;
    end
    k = 0;
    while (nv_busy === 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    chk("nv_cycles", k, dur);
    motor_spinning = 1'b0;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    put(cfgsh_pkg::OFS_SPEED_DETECT_CFG, cfgsh_pkg::LEN_32, 64'h11223344, 4);
    chk("slot0", slot(0), 64'h11223344);
    put(cfgsh_pkg::OFS_GATE_DRIVE_CFG_A, cfgsh_pkg::LEN_64, 64'ha1b2c3d4e5f60718, 8);
    chk("slot18_19", {slot(19), slot(18)}, 64'ha1b2c3d4e5f60718);
    bus.rd(cfgsh_pkg::OFS_GATE_DRIVE_CFG_A, cfgsh_pkg::LEN_64, 8, rv);
    chk("rd64", rv, 64'ha1b2c3d4e5f60718);
    bus.rd(cfgsh_pkg::OFS_GATE_DRIVE_CFG_B, cfgsh_pkg::LEN_32, 4, rv);
    chk("rd32", rv, 64'ha1b2c3d4);
  endtask
  task automatic t_len();
    put(cfgsh_pkg::OFS_STARTUP_CFG_A, cfgsh_pkg::LEN_32, 64'h55667788, 3);
    chk("short", slot(1), 64'h0);
    put(cfgsh_pkg::OFS_STARTUP_CFG_A, 2'h3, 64'h55667788, 4);
    chk("len_rsv", slot(1), 64'h0);
    put(cfgsh_pkg::OFS_STARTUP_CFG_A + 12'h001, cfgsh_pkg::LEN_16, 64'hbeef, 2);
    put(cfgsh_pkg::OFS_STARTUP_CFG_A, cfgsh_pkg::LEN_16, 64'h1234, 2);
    chk("len16", slot(1), 64'hbeef1234);
    bus.rd(cfgsh_pkg::OFS_STARTUP_CFG_A + 12'h001, cfgsh_pkg::LEN_16, 2, rv);
    chk("rd16", rv, 64'hbeef);
    // CRC on: the check byte counts, so four bytes fall short and five land
    for (int n = 4; n < 6; n++) begin
      bus.wr(cfgsh_pkg::OFS_STARTUP_CFG_B, {1'b1, cfgsh_pkg::LEN_32}, 64'h990a0b0c0d, n, ok);
      repeat (12) @(negedge sys_clk);
      chk("crc_ack", ok, 1);
      chk("crc_len", slot(2), (n == 5) ? 64'h0a0b0c0d : 64'h0);
    end
  endtask
  task automatic t_nv();
    nv_cmd(cfgsh_pkg::CMD_COMMIT, 1'b1, 0);
    nv_cmd(cfgsh_pkg::CMD_COMMIT, 1'b0, int'(cfgsh_pkg::COMMIT_CYCLES));
    put(cfgsh_pkg::OFS_SPEED_DETECT_CFG, cfgsh_pkg::LEN_32, 64'h0, 4);
    nv_cmd(cfgsh_pkg::CMD_LOAD, 1'b1, 0);
    nv_cmd(32'h8a500001, 1'b0, 0);
    chk("no_load", slot(0), 64'h0);
    nv_cmd(cfgsh_pkg::CMD_LOAD, 1'b0, cfgsh_pkg::SHADOW_COUNT);
    chk("ld0", slot(0), 64'h11223344);
    chk("ld1", slot(1), 64'hbeef1234);
    chk("ld18", {slot(19), slot(18)}, 64'ha1b2c3d4e5f60718);
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    repeat (6) @(negedge sys_clk);
    chk("busy0", nv_busy, 0);
    chk("oe0", sda_oe_n, 1);
    chk("cfg0", |cfg_words, 0);
    chk("out0", sda_out, 0);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_regs();
    t_len();
    t_nv();
    end_sim();
  end
  initial begin
    #600000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
